// ### logic/hfb_pkg.sv
`default_nettype none
package hfb_pkg;

    // ------------------------------------------------------------
    // Register addresses on the controller memory bus
    // ------------------------------------------------------------
    localparam logic [15:0] HFB_ADDR_RX_BIT_COUNT = 16'hdc00;
    localparam logic [15:0] HFB_ADDR_RX_BUF_QUEUE = 16'hdc01;
    localparam logic [15:0] HFB_ADDR_TX_BIT_COUNT = 16'hdc02;
    localparam logic [15:0] HFB_ADDR_TX_QUEUE_BUF = 16'hdc03;
    localparam logic [15:0] HFB_ADDR_CTRL_STATUS = 16'hdc04;
    localparam logic [15:0] HFB_ADDR_ZD_DATA = 16'hdc08;
    localparam logic [15:0] HFB_ADDR_ZD_STATUS = 16'hdc09;
    localparam logic [15:0] HFB_ADDR_CHECK_LOW = 16'hdc0a;
    localparam logic [15:0] HFB_ADDR_CHECK_HIGH = 16'hdc0b;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HFB_CS_TX_READY = 0;
    localparam int HFB_CS_RX_LOADED = 1;
    localparam int HFB_CS_THR_SEL = 2;
    localparam int HFB_CS_TX_LEVEL = 3;
    localparam int HFB_CS_TX_LOADED = 4;
    localparam int HFB_CS_RX_EMPTY = 5;
    localparam int HFB_CS_RESET = 6;
    localparam int HFB_ZD_READY = 0;
    localparam int HFB_ZD_FRAME_END = 1;
    localparam int HFB_ZD_CHECK_OK = 2;
    localparam int HFB_ZD_IN_EMPTY = 3;
    localparam int HFB_ZD_SOFT_RESET = 7;

    // ------------------------------------------------------------
    // Sizes, patterns, reset values
    // ------------------------------------------------------------
    localparam int HFB_QUEUE_DEPTH = 21;
    localparam int HFB_BITBUF_BYTES = 16;
    localparam logic [7:0] HFB_BITBUF_BITS = 8'd128;
    localparam logic [4:0] HFB_BITBUF_LAST = 5'd16;
    localparam logic [7:0] HFB_FLAG = 8'h7e;
    localparam logic [2:0] HFB_STUFF_RUN = 3'd5;
    localparam logic [2:0] HFB_FLAG_RUN = 3'd6;
    localparam logic [4:0] HFB_THR_LOW = 5'd11;
    localparam logic [4:0] HFB_THR_HIGH = 5'd16;
    localparam logic [15:0] HFB_CRC_INIT = 16'hffff;
    localparam logic [15:0] HFB_CRC_POLY = 16'h8408;
    localparam logic [15:0] HFB_CRC_GOOD = 16'hf0b8;
    localparam logic [7:0] HFB_RDATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hfb_bus_req_s;

    typedef enum logic [1:0] {
        HFB_TX_IDLE = 2'b00,
        HFB_TX_SEND = 2'b01
    } hfb_tx_state_e;

endpackage
`default_nettype wire

// ### logic/hfb_engine.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Byte queue in flip-flops
// ------------------------------------------------------------
module hfb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 21,
    parameter int LW = $clog2(DEPTH + 1),
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [LW-1:0] level
);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_idx_q;
    logic [AW-1:0] rd_idx_q;
    logic [LW-1:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign in_ready = cnt_q != LW'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_idx_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage, no reset needed for the data words
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_idx_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            cnt_q <= '0;
        end else if (clr) begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_idx_q <= (wr_idx_q == AW'(DEPTH - 1)) ? '0 : wr_idx_q + 1'b1;
            end
            if (pop) begin
                rd_idx_q <= (rd_idx_q == AW'(DEPTH - 1)) ? '0 : rd_idx_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Flag and bit-stuffing engine
// ------------------------------------------------------------
module hfb_engine (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire hfb_pkg::hfb_bus_req_s bus_req,
    output logic [7:0] bus_rdata
);
    import hfb_pkg::*;

    // One bit of frame check per loop pass, reflected polynomial
    function automatic logic [15:0] hfb_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ HFB_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Decode and control bits
    // ------------------------------------------------------------
    logic wr_rx_count, wr_rx_buf, wr_tx_count, wr_tx_queue, wr_cs, wr_zd_in, wr_zd_stat;
    logic rd_rx_queue, rd_tx_buf, rd_zd_out;
    logic cs_rx_loaded_q, cs_thr_sel_q, cs_reset_q;
    logic zd_srst;

    assign wr_rx_count = bus_req.wr && bus_req.addr == HFB_ADDR_RX_BIT_COUNT;
    assign wr_rx_buf = bus_req.wr && bus_req.addr == HFB_ADDR_RX_BUF_QUEUE;
    assign wr_tx_count = bus_req.wr && bus_req.addr == HFB_ADDR_TX_BIT_COUNT;
    assign wr_tx_queue = bus_req.wr && bus_req.addr == HFB_ADDR_TX_QUEUE_BUF;
    assign wr_cs = bus_req.wr && bus_req.addr == HFB_ADDR_CTRL_STATUS;
    assign wr_zd_in = bus_req.wr && bus_req.addr == HFB_ADDR_ZD_DATA;
    assign wr_zd_stat = bus_req.wr && bus_req.addr == HFB_ADDR_ZD_STATUS;
    assign rd_rx_queue = bus_req.rd && bus_req.addr == HFB_ADDR_RX_BUF_QUEUE;
    assign rd_tx_buf = bus_req.rd && bus_req.addr == HFB_ADDR_TX_QUEUE_BUF;
    assign rd_zd_out = bus_req.rd && bus_req.addr == HFB_ADDR_ZD_DATA;
    assign zd_srst = wr_zd_stat && bus_req.wdata[HFB_ZD_SOFT_RESET];

    logic rx_done;

    // Control bits; the device clear of rx loaded loses to a software set
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_rx_loaded_q <= 1'b0;
            cs_thr_sel_q <= 1'b0;
            cs_reset_q <= 1'b0;
        end else if (wr_cs) begin
            cs_rx_loaded_q <= bus_req.wdata[HFB_CS_RX_LOADED];
            cs_thr_sel_q <= bus_req.wdata[HFB_CS_THR_SEL];
            cs_reset_q <= bus_req.wdata[HFB_CS_RESET];
        end else if (rx_done) begin
            cs_rx_loaded_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive bit buffer and deframer
    // ------------------------------------------------------------
    logic [7:0] rx_buf_q [HFB_BITBUF_BYTES];
    logic [4:0] rx_wptr_q;
    logic [7:0] rx_rptr_q;
    logic [7:0] rx_left_q;
    logic [7:0] rx_sr_q;
    logic [2:0] rx_cnt_q;
    logic rx_sync_q;
    logic rx_step, rx_bit, rx_is_flag, rxq_push, rxq_ready, rxq_valid;
    logic [7:0] rx_sr_n, rxq_data;
    logic [4:0] rxq_level;

    // Stall on a full queue so no byte is ever dropped
    assign rx_step = rx_left_q != '0 && rxq_ready;
    assign rx_bit = rx_buf_q[rx_rptr_q[6:3]][rx_rptr_q[2:0]];
    assign rx_sr_n = {rx_bit, rx_sr_q[7:1]};
    assign rx_is_flag = rx_sr_n == HFB_FLAG;
    assign rxq_push = rx_step && !rx_is_flag && rx_sync_q && rx_cnt_q == 3'd7;
    assign rx_done = rx_step && rx_left_q == 8'd1;

    // Raw bytes from the controller
    always_ff @(posedge clk_sys) begin
        if (wr_rx_buf && rx_wptr_q != HFB_BITBUF_LAST) begin
            rx_buf_q[rx_wptr_q[3:0]] <= bus_req.wdata;
        end
    end

    // Bit walk; a flag re-aligns byte boundaries
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_wptr_q <= '0;
            rx_rptr_q <= '0;
            rx_left_q <= '0;
            rx_sr_q <= '0;
            rx_cnt_q <= '0;
            rx_sync_q <= 1'b0;
        end else if (cs_reset_q) begin
            rx_wptr_q <= '0;
            rx_rptr_q <= '0;
            rx_left_q <= '0;
            rx_sr_q <= '0;
            rx_cnt_q <= '0;
            rx_sync_q <= 1'b0;
        end else begin
            if (wr_rx_buf && rx_wptr_q != HFB_BITBUF_LAST) begin
                rx_wptr_q <= rx_wptr_q + 1'b1;
            end else if (rx_done) begin
                rx_wptr_q <= '0;
            end
            if (wr_rx_count) begin
                rx_left_q <= (bus_req.wdata > HFB_BITBUF_BITS) ? HFB_BITBUF_BITS : bus_req.wdata;
                rx_rptr_q <= '0;
            end else if (rx_step) begin
                rx_left_q <= rx_left_q - 1'b1;
                rx_rptr_q <= rx_rptr_q + 1'b1;
                rx_sr_q <= rx_sr_n;
                if (rx_is_flag) begin
                    rx_cnt_q <= '0;
                    rx_sync_q <= 1'b1;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 1'b1;
                end
            end
        end
    end

    hfb_fifo #(.W(8), .DEPTH(HFB_QUEUE_DEPTH)) u_rx_queue (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clr(cs_reset_q),
        .in_valid(rxq_push),
        .in_data(rx_sr_n),
        .in_ready(rxq_ready),
        .out_valid(rxq_valid),
        .out_data(rxq_data),
        .out_ready(rd_rx_queue),
        .level(rxq_level)
    );

    // ------------------------------------------------------------
    // Transmit framer and bit buffer
    // ------------------------------------------------------------
    hfb_tx_state_e tx_state_q;
    logic [7:0] tx_byte_q;
    logic [2:0] tx_bidx_q;
    logic [2:0] tx_ones_q;
    logic tx_data_mode_q;
    logic [7:0] tx_left_q;
    logic [7:0] tx_bptr_q;
    logic [7:0] tx_buf_q [HFB_BITBUF_BYTES];
    logic [4:0] tx_rd_q;
    logic tx_loaded_q, tx_ready_q;
    logic txq_ready, txq_valid, txq_pop, tx_emit, tx_stuff, tx_bit, tx_flag_load;
    logic [7:0] txq_data;
    logic [4:0] txq_level, tx_thr;

    assign tx_thr = cs_thr_sel_q ? HFB_THR_HIGH : HFB_THR_LOW;
    // Bit buffer full stalls the framer; counts above its size are clipped
    assign tx_emit = tx_state_q == HFB_TX_SEND && tx_left_q != '0 && !tx_bptr_q[7];
    assign tx_stuff = tx_data_mode_q && tx_ones_q == HFB_STUFF_RUN;
    assign tx_bit = tx_stuff ? 1'b0 : tx_byte_q[tx_bidx_q];
    assign txq_pop = tx_state_q == HFB_TX_IDLE && tx_left_q != '0 && txq_valid;
    assign tx_flag_load = tx_state_q == HFB_TX_IDLE && tx_left_q != '0 && !txq_valid;

    hfb_fifo #(.W(8), .DEPTH(HFB_QUEUE_DEPTH)) u_tx_queue (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clr(cs_reset_q),
        .in_valid(wr_tx_queue),
        .in_data(bus_req.wdata),
        .in_ready(txq_ready),
        .out_valid(txq_valid),
        .out_data(txq_data),
        .out_ready(txq_pop),
        .level(txq_level)
    );

    // Framed bits into the buffer, lsb first
    always_ff @(posedge clk_sys) begin
        if (tx_emit) begin
            tx_buf_q[tx_bptr_q[6:3]][tx_bptr_q[2:0]] <= tx_bit;
        end
    end

    // Framer state: fetch a byte or a flag, then shift it out
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_state_q <= HFB_TX_IDLE;
            tx_byte_q <= '0;
            tx_bidx_q <= '0;
            tx_ones_q <= '0;
            tx_data_mode_q <= 1'b0;
        end else if (cs_reset_q) begin
            tx_state_q <= HFB_TX_IDLE;
            tx_byte_q <= '0;
            tx_bidx_q <= '0;
            tx_ones_q <= '0;
            tx_data_mode_q <= 1'b0;
        end else begin
            case (tx_state_q)
                HFB_TX_IDLE: begin
                    if (txq_pop) begin
                        tx_byte_q <= txq_data;
                        tx_data_mode_q <= 1'b1;
                        tx_bidx_q <= '0;
                        tx_state_q <= HFB_TX_SEND;
                    end else if (tx_flag_load) begin
                        tx_byte_q <= HFB_FLAG;
                        tx_data_mode_q <= 1'b0;
                        tx_bidx_q <= '0;
                        tx_state_q <= HFB_TX_SEND;
                    end
                end
                HFB_TX_SEND: begin
                    if (tx_emit) begin
                        if (tx_stuff || !tx_data_mode_q) begin
                            tx_ones_q <= '0;
                        end else begin
                            tx_ones_q <= tx_bit ? tx_ones_q + 1'b1 : 3'd0;
                        end
                        if (!tx_stuff) begin
                            tx_bidx_q <= tx_bidx_q + 1'b1;
                            if (tx_bidx_q == 3'd7) begin
                                tx_state_q <= HFB_TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    tx_state_q <= HFB_TX_IDLE;
                end
            endcase
        end
    end

    // Bit count, buffer pointers and loaded flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_left_q <= '0;
            tx_bptr_q <= '0;
            tx_rd_q <= '0;
            tx_loaded_q <= 1'b0;
        end else if (cs_reset_q) begin
            tx_left_q <= '0;
            tx_bptr_q <= '0;
            tx_rd_q <= '0;
            tx_loaded_q <= 1'b0;
        end else if (wr_tx_count) begin
            tx_left_q <= (bus_req.wdata > HFB_BITBUF_BITS) ? HFB_BITBUF_BITS : bus_req.wdata;
            tx_bptr_q <= '0;
            tx_rd_q <= '0;
            tx_loaded_q <= bus_req.wdata == '0;
        end else begin
            if (tx_emit) begin
                tx_left_q <= tx_left_q - 1'b1;
                tx_bptr_q <= tx_bptr_q + 1'b1;
                if (tx_left_q == 8'd1) begin
                    tx_loaded_q <= 1'b1;
                end
            end
            if (rd_tx_buf && tx_rd_q != HFB_BITBUF_LAST) begin
                tx_rd_q <= tx_rd_q + 1'b1;
            end
        end
    end

    // Ready stays high from threshold until drained and a flag goes out
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready_q <= 1'b0;
        end else if (cs_reset_q) begin
            tx_ready_q <= 1'b0;
        end else if (txq_level >= tx_thr) begin
            tx_ready_q <= 1'b1;
        end else if (tx_flag_load) begin
            tx_ready_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Zero-deletion helper
    // ------------------------------------------------------------
    logic [7:0] zd_in_q, zd_acc_q, zd_out_q;
    logic [2:0] zd_bidx_q, zd_ones_q, zd_acc_cnt_q;
    logic zd_full_q, zd_ready_q, zd_end_q, zd_ok_q;
    logic [15:0] zd_crc_q;
    logic zd_step, zd_bit, zd_commit;
    logic [7:0] zd_acc_n;

    // A finished byte waits while the previous one is unread
    assign zd_step = zd_full_q && !(zd_ready_q && zd_acc_cnt_q == 3'd7);
    assign zd_bit = zd_in_q[zd_bidx_q];
    assign zd_acc_n = {zd_bit, zd_acc_q[7:1]};
    assign zd_commit = zd_step && zd_ones_q < HFB_STUFF_RUN && zd_acc_cnt_q == 3'd7;

    // Input side and bit walk
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zd_in_q <= '0;
            zd_full_q <= 1'b0;
            zd_bidx_q <= '0;
            zd_ones_q <= '0;
            zd_acc_q <= '0;
            zd_acc_cnt_q <= '0;
        end else if (zd_srst) begin
            zd_full_q <= 1'b0;
            zd_bidx_q <= '0;
            zd_ones_q <= '0;
            zd_acc_cnt_q <= '0;
        end else if (wr_zd_in) begin
            zd_in_q <= bus_req.wdata;
            zd_full_q <= 1'b1;
            zd_bidx_q <= '0;
        end else if (zd_step) begin
            zd_bidx_q <= zd_bidx_q + 1'b1;
            zd_full_q <= zd_bidx_q != 3'd7;
            if (zd_ones_q == HFB_STUFF_RUN) begin
                // Stuffed zero is dropped; a sixth one means flag or abort
                zd_ones_q <= zd_bit ? HFB_FLAG_RUN : 3'd0;
            end else if (zd_ones_q == HFB_FLAG_RUN) begin
                zd_ones_q <= zd_bit ? HFB_FLAG_RUN : 3'd0;
                zd_acc_cnt_q <= '0;
            end else begin
                zd_ones_q <= zd_bit ? zd_ones_q + 1'b1 : 3'd0;
                zd_acc_q <= zd_acc_n;
                zd_acc_cnt_q <= zd_acc_cnt_q + 1'b1;
            end
        end
    end

    // Output byte, flags and frame check
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zd_out_q <= '0;
            zd_ready_q <= 1'b0;
            zd_end_q <= 1'b0;
            zd_ok_q <= 1'b0;
            zd_crc_q <= HFB_CRC_INIT;
        end else if (zd_srst) begin
            zd_ready_q <= 1'b0;
            zd_end_q <= 1'b0;
            zd_ok_q <= 1'b0;
            zd_crc_q <= HFB_CRC_INIT;
        end else begin
            if (zd_commit) begin
                zd_out_q <= zd_acc_n;
                zd_ready_q <= 1'b1;
                zd_crc_q <= hfb_crc_byte(zd_crc_q, zd_acc_n);
            end else if (rd_zd_out) begin
                zd_ready_q <= 1'b0;
            end
            // Only whole bytes feed the check; the first five ones of a flag feed it when they complete a byte
            if (zd_step && zd_ones_q == HFB_FLAG_RUN && !zd_bit && !wr_zd_in) begin
                zd_end_q <= 1'b1;
                zd_ok_q <= zd_crc_q == HFB_CRC_GOOD;
                zd_crc_q <= HFB_CRC_INIT;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] cs_status, zd_status;

    assign cs_status = {1'b0, cs_reset_q, !rxq_valid, tx_loaded_q,
                        txq_level <= tx_thr, cs_thr_sel_q, cs_rx_loaded_q, tx_ready_q};
    assign zd_status = {4'h0, !zd_full_q, zd_ok_q, zd_end_q, zd_ready_q};

    // Registered answer; unmapped or write-only addresses read zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= HFB_RDATA_RESET;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                HFB_ADDR_RX_BUF_QUEUE: bus_rdata <= rxq_valid ? rxq_data : 8'h00;
                HFB_ADDR_TX_QUEUE_BUF: bus_rdata <= tx_buf_q[tx_rd_q[3:0]];
                HFB_ADDR_CTRL_STATUS: bus_rdata <= cs_status;
                HFB_ADDR_ZD_DATA: bus_rdata <= zd_out_q;
                HFB_ADDR_ZD_STATUS: bus_rdata <= zd_status;
                HFB_ADDR_CHECK_LOW: bus_rdata <= zd_crc_q[7:0];
                HFB_ADDR_CHECK_HIGH: bus_rdata <= zd_crc_q[15:8];
                default: bus_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verif/hfb_engine_props.sv
`timescale 1ns/1ps
`default_nettype none
module hfb_engine_props
    import hfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire hfb_pkg::hfb_bus_req_s bus_req,
    input wire logic [7:0] bus_rdata
);
    // ------------------------------------------------------------
    // Bus relations seen from the pins
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Decoded strobes, named once to keep properties short
    wire logic rd_cs = bus_req.rd && bus_req.addr == HFB_ADDR_CTRL_STATUS;
    wire logic wr_cs = bus_req.wr && bus_req.addr == HFB_ADDR_CTRL_STATUS;
    wire logic rd_zs = bus_req.rd && bus_req.addr == HFB_ADDR_ZD_STATUS;
    wire logic zrst = bus_req.wr && bus_req.addr == HFB_ADDR_ZD_STATUS && bus_req.wdata[7];
    wire logic rd_ck = bus_req.rd && bus_req.addr inside {HFB_ADDR_CHECK_LOW, HFB_ADDR_CHECK_HIGH};
    chk_unmapped_read_zero: assert property (bus_req.rd && bus_req.addr == 16'hdc05 |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_count_reads_zero: assert property (bus_req.rd && bus_req.addr inside {16'hdc00, 16'hdc02}
        |=> bus_rdata == 8'h00)
        else $error("write-only count read not zero");
    chk_rdata_holds: assert property (!bus_req.rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    chk_thr_sel_echo: assert property (wr_cs ##1 rd_cs |=> bus_rdata[2] == $past(bus_req.wdata[2], 2))
        else $error("threshold select not echoed");
    chk_reset_bit_echo: assert property (wr_cs ##1 rd_cs |=> bus_rdata[6] == $past(bus_req.wdata[6], 2))
        else $error("reset bit not echoed");
    chk_reset_empties_queue: assert property (wr_cs && bus_req.wdata[6] ##1 rd_cs |=> bus_rdata[5])
        else $error("queue not empty under reset");
    chk_txcount_clears_loaded: assert property (bus_req.wr && bus_req.addr == HFB_ADDR_TX_BIT_COUNT
        && bus_req.wdata >= 8'd2 ##1 rd_cs |=> !bus_rdata[4])
        else $error("tx loaded not cleared by count write");
    chk_zd_reset_flags: assert property (zrst ##1 rd_zs |=> bus_rdata[3:0] == 4'h8)
        else $error("helper flags wrong after soft reset");
    chk_zd_write_busy: assert property (bus_req.wr && bus_req.addr == HFB_ADDR_ZD_DATA ##1 rd_zs
        |=> !bus_rdata[3])
        else $error("input empty after write");
    chk_check_init_value: assert property (zrst ##1 rd_ck |=> bus_rdata == 8'hff)
        else $error("check value not initial");
    cov_tx_read: cover property (bus_req.rd && bus_req.addr == HFB_ADDR_TX_QUEUE_BUF);
    cov_rx_start: cover property (bus_req.wr && bus_req.addr == HFB_ADDR_RX_BIT_COUNT);
    cov_zd_write: cover property (bus_req.wr && bus_req.addr == HFB_ADDR_ZD_DATA);
endmodule
bind hfb_engine hfb_engine_props i_hfb_engine_props (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata));
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hfb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    hfb_bus_req_s bus_req = '0;
    logic [7:0] bus_rdata;
    logic [7:0] v;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    hfb_engine i_hfb_engine (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata));
    // ------------------------------------------------------------
    // Clock, watchdog and bus helpers
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobes go up at a falling edge, so each request is taken by exactly one rising edge
    task automatic put(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
        bus_req <= '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        put(1'b1, a, d);
        idle(1);
    endtask
    // Write then read on the very next cycle, answer sampled one cycle later
    task automatic wrrd(input logic [15:0] wa, input logic [7:0] wd, input logic [15:0] ra);
        put(1'b1, wa, wd);
        put(1'b0, ra, 8'h00);
        idle(1);
        v = bus_rdata;
    endtask
    task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        put(1'b0, a, 8'h00);
        idle(1);
        chk(what, bus_rdata & m, e);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc("status", HFB_ADDR_CTRL_STATUS, 8'hff, 8'h28);
        rdc("zd status", HFB_ADDR_ZD_STATUS, 8'hff, 8'h08);
        rdc("check low", HFB_ADDR_CHECK_LOW, 8'hff, 8'hff);
        rdc("check high", HFB_ADDR_CHECK_HIGH, 8'hff, 8'hff);
        rdc("empty rx queue", HFB_ADDR_RX_BUF_QUEUE, 8'hff, 8'h00);
        rdc("unmapped", 16'hdc05, 8'hff, 8'h00);
        rdc("rx count", HFB_ADDR_RX_BIT_COUNT, 8'hff, 8'h00);
    endtask
    task automatic t_tx();
        wrrd(HFB_ADDR_TX_BIT_COUNT, 8'd8, HFB_ADDR_CTRL_STATUS);
        chk("tx busy", v & 8'h10, 8'h00);
        idle(20);
        rdc("tx after flag", HFB_ADDR_CTRL_STATUS, 8'h11, 8'h10);
        rdc("idle flag", HFB_ADDR_TX_QUEUE_BUF, 8'hff, 8'h7e);
        wr(HFB_ADDR_TX_QUEUE_BUF, 8'hff);
        wr(HFB_ADDR_TX_BIT_COUNT, 8'd9);
        idle(20);
        rdc("stuffed byte", HFB_ADDR_TX_QUEUE_BUF, 8'hff, 8'hdf);
        rdc("stuffed tail", HFB_ADDR_TX_QUEUE_BUF, 8'h01, 8'h01);
    endtask
    task automatic t_thr();
        wr(HFB_ADDR_CTRL_STATUS, 8'h00);
        repeat (11) wr(HFB_ADDR_TX_QUEUE_BUF, 8'h55);
        rdc("level 11", HFB_ADDR_CTRL_STATUS, 8'h09, 8'h09);
        wr(HFB_ADDR_TX_QUEUE_BUF, 8'h55);
        rdc("level 12", HFB_ADDR_CTRL_STATUS, 8'h08, 8'h00);
        wrrd(HFB_ADDR_CTRL_STATUS, 8'h04, HFB_ADDR_CTRL_STATUS);
        chk("thr 16", v & 8'h0c, 8'h0c);
        wrrd(HFB_ADDR_CTRL_STATUS, 8'h44, HFB_ADDR_CTRL_STATUS);
        chk("framer reset", v & 8'h60, 8'h60);
        wr(HFB_ADDR_CTRL_STATUS, 8'h00);
    endtask
    task automatic t_rx();
        wr(HFB_ADDR_RX_BUF_QUEUE, 8'h7e);
        wr(HFB_ADDR_RX_BUF_QUEUE, 8'ha5);
        wr(HFB_ADDR_RX_BUF_QUEUE, 8'h7e);
        wr(HFB_ADDR_CTRL_STATUS, 8'h02);
        wr(HFB_ADDR_RX_BIT_COUNT, 8'd24);
        idle(40);
        rdc("rx consumed", HFB_ADDR_CTRL_STATUS, 8'h22, 8'h00);
        rdc("deframed", HFB_ADDR_RX_BUF_QUEUE, 8'hff, 8'ha5);
        rdc("rx drained", HFB_ADDR_CTRL_STATUS, 8'h20, 8'h20);
    endtask
    task automatic t_zd();
        wrrd(HFB_ADDR_ZD_STATUS, 8'h80, HFB_ADDR_CHECK_LOW);
        chk("check init", v, 8'hff);
        wrrd(HFB_ADDR_ZD_DATA, 8'h55, HFB_ADDR_ZD_STATUS);
        chk("input busy", v & 8'h08, 8'h00);
        idle(12);
        rdc("zd ready", HFB_ADDR_ZD_STATUS, 8'h0f, 8'h09);
        rdc("zd out", HFB_ADDR_ZD_DATA, 8'hff, 8'h55);
        rdc("zd ready clear", HFB_ADDR_ZD_STATUS, 8'h01, 8'h00);
        wr(HFB_ADDR_ZD_DATA, 8'h7e);
        idle(12);
        rdc("frame end", HFB_ADDR_ZD_STATUS, 8'h0e, 8'h0a);
        rdc("frame end held", HFB_ADDR_ZD_STATUS, 8'h02, 8'h02);
        wrrd(HFB_ADDR_ZD_STATUS, 8'h80, HFB_ADDR_ZD_STATUS);
        chk("soft reset", v & 8'h0f, 8'h08);
    endtask
    // Reset for 20 cycles, released off the rising edge
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_tx();
        t_thr();
        t_rx();
        t_zd();
        give_verdict();
    end
endmodule
`default_nettype wire
